// ===== hw/column_driver_pkg.sv
// Package with widths, reset values and signal groups of the serial column driver
package column_driver_pkg;

   // ---------------------------------------------------------------
   // Sizes and reset values
   // ---------------------------------------------------------------
   localparam int          STAGE_COUNT      = 32;
   localparam int          SYNC_DEPTH       = 2;
   localparam logic [31:0] STAGE_RESET      = 32'h0000_0000;
   localparam logic [3:0]  PIN_SYNC_RESET   = 4'h0;

   typedef logic [STAGE_COUNT-1:0] stage_vec_t;

   // ---------------------------------------------------------------
   // Pin groups
   // ---------------------------------------------------------------
   typedef struct packed {
      logic serial_data;      // Serial data input
      logic shift_clk;        // Shift clock pin, sampled
      logic strobe_n;         // Active-low strobe
      logic force_all_low_n;  // Active-low force_all_low_n
   } ctrl_pins_s;

   typedef struct packed {
      stage_vec_t electrodes; // Bit 0 is electrode_out_first, bit 31 electrode_out_last
      logic       serial_out; // Cascade output
   } drive_pins_s;

endpackage : column_driver_pkg

// ===== hw/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous input pins
module pin_sync
  import column_driver_pkg::*;
#(
   parameter int               WIDTH     = 4,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             sys_clk,   // System clock
   input  wire logic             rst_n,     // Synchronised reset, active low
   input  wire logic [WIDTH-1:0] async_in,  // Raw pin levels
   output logic      [WIDTH-1:0] sync_out   // Synchronised levels
);
   import column_driver_pkg::*;

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_sync_out;

   always_comb begin
      next_meta     = async_in;
      next_sync_out = meta;
   end

   // Both stages reset to a fixed level, so logic behind sees an edge at release only for a pin at the other level
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta     <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta     <= next_meta;
         sync_out <= next_sync_out;
      end
   end

endmodule : pin_sync

// ===== hw/plasma_serial_column_driver.sv
// Serial-in, 32-electrode parallel-out display column driver with cascade output
//
// How it works
// - Each rising edge of the shift clock moves the register one stage, with the first stage taking serial data.
// - With strobe and force_all_low_n both high every electrode output sits high.
// - With strobe low and force_all_low_n high, an electrode whose stage holds low drives low.
// - With strobe low and force_all_low_n high, an electrode whose stage holds high stays high.
// - With force_all_low_n low every electrode output is low regardless of data and strobe.
// - The 32 stage values, as captured at the latest clock edge, feed the output selection.
// - The serial cascade output always shows the last stage.
module plasma_serial_column_driver
  import column_driver_pkg::*;
(
   input  wire logic                          sys_clk,  // System clock, 100 MHz
   input  wire logic                          arst_n,   // Asynchronous reset, active low
   input  wire column_driver_pkg::ctrl_pins_s pins_in,  // Data, clock, strobe, force_all_low_n pins
   output column_driver_pkg::drive_pins_s     pins_out  // Electrodes and cascade output
);
   import column_driver_pkg::*;

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic [1:0] rst_pipe;
   logic [1:0] next_rst_pipe;
   logic       rst_n;

   always_comb begin
      next_rst_pipe = {rst_pipe[0], 1'b1};
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= next_rst_pipe;
      end
   end

   // Release is taken from the second flop only, so it never comes out metastable
   assign rst_n = rst_pipe[1];

   // ---------------------------------------------------------------
   // Pin synchronisation
   // ---------------------------------------------------------------
   // The device has no reset of its own; the sync flops start at zero, and
   // shift_clk starting low means a pin held high at release reads as one edge.
   logic [3:0]  pins_sync;
   logic        data_s;
   logic        clk_s;
   logic        strobe_n_s;
   logic        force_all_low_n_n_s;

   pin_sync #(
      .WIDTH     (4),
      .RESET_VAL (PIN_SYNC_RESET)
   ) u_pin_sync (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .async_in  (pins_in),
      .sync_out  (pins_sync)
   );

   assign {data_s, clk_s, strobe_n_s, force_all_low_n_n_s} = pins_sync;

   // ---------------------------------------------------------------
   // Shift clock edge detect
   // ---------------------------------------------------------------
   logic clk_prev;
   logic next_clk_prev;
   logic shift_en;

   always_comb begin
      next_clk_prev = clk_s;
   end

   // A pin held high for many cycles still gives one pulse; phases shorter
   // than one system clock cycle can be lost, so the far side must keep them long
   assign shift_en = clk_s & ~clk_prev;

   // ---------------------------------------------------------------
   // Shift register
   // ---------------------------------------------------------------
   // Zero at reset is a choice that keeps the stages free of unknowns
   stage_vec_t stages;
   stage_vec_t next_stages;

   always_comb begin
      next_stages = stages;
      if (shift_en) begin
         next_stages = {stages[STAGE_COUNT-2:0], data_s};
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_prev <= 1'b0;
         stages   <= STAGE_RESET;
      end else begin
         clk_prev <= next_clk_prev;
         stages   <= next_stages;
      end
   end

   // ---------------------------------------------------------------
   // Output selection
   // ---------------------------------------------------------------
   drive_pins_s next_out;
   // Force_all_low_n is tested first so that it overrides strobe

   always_comb begin
      next_out.serial_out = stages[STAGE_COUNT-1];
      if (!force_all_low_n_n_s) begin
         next_out.electrodes = '0;
      end else if (!strobe_n_s) begin
         next_out.electrodes = stages;
      end else begin
         next_out.electrodes = '1;
      end
   end

   // Registered outputs; during reset they show the force_all_low_n level of all low
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pins_out <= '0;
      end else begin
         pins_out <= next_out;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence rise_seen;
      shift_en;
   endsequence

   sequence quiet_cycle;
      !shift_en;
   endsequence

   sequence idle_phase;
      strobe_n_s && force_all_low_n_n_s;
   endsequence

   sequence strobe_phase;
      !strobe_n_s && force_all_low_n_n_s;
   endsequence

   sequence force_all_low_n_phase;
      !force_all_low_n_n_s;
   endsequence

   shift_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rise_seen |=> (stages == {$past(stages[STAGE_COUNT-2:0]), $past(data_s)}))
      else $error("shift step wrong");

   idle_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      quiet_cycle |=> $stable(stages))
      else $error("stages changed without clock edge");

   all_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (strobe_n_s && force_all_low_n_n_s) |=> (pins_out.electrodes == '1))
      else $error("outputs not all high");

   strobe_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!strobe_n_s && force_all_low_n_n_s) |=> ((pins_out.electrodes | $past(stages)) == $past(stages)))
      else $error("low stage not driven low");

   strobe_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!strobe_n_s && force_all_low_n_n_s) |=> ((pins_out.electrodes & $past(stages)) == $past(stages)))
      else $error("high stage not kept high");

   force_all_low_n_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !force_all_low_n_n_s |=> (pins_out.electrodes == '0))
      else $error("force_all_low_n did not force low");

   stage_feed_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!strobe_n_s && force_all_low_n_n_s) [*2] |=> (pins_out.electrodes == $past(stages)))
      else $error("outputs not fed from stages");

   cascade_out_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      1'b1 |=> (pins_out.serial_out == $past(stages[STAGE_COUNT-1])))
      else $error("cascade output wrong");

   // ---------------------------------------------------------------
   // Checks across steps and mode changes
   // ---------------------------------------------------------------
   // One pin rise must give one shift only, however long the pin stays high
   edge_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rise_seen |=> !shift_en)
      else $error("shift enable longer than one cycle");

   first_stage_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rise_seen |=> (stages[0] == $past(data_s)))
      else $error("first stage missed serial data");

   // The bit below the last stage reaches the cascade pin two cycles on
   cascade_shift_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rise_seen |=> ##1 (pins_out.serial_out == $past(stages[STAGE_COUNT-2], 2)))
      else $error("cascade output did not follow shift");

   // Entering strobe shows the stages at once, with no stale all-high cycle
   strobe_enter_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      idle_phase ##1 strobe_phase |=> (pins_out.electrodes == $past(stages)))
      else $error("strobe entry did not show stages");

   force_all_low_n_exit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      force_all_low_n_phase ##1 idle_phase |=> (pins_out.electrodes == '1))
      else $error("outputs not high after force_all_low_n");

   force_all_low_n_wins_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!force_all_low_n_n_s && !strobe_n_s) |=> (pins_out.electrodes == '0))
      else $error("strobe overrode force_all_low_n");

   // Outputs stand while neither stages nor controls move
   out_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!$past(shift_en) && $stable(strobe_n_s) && $stable(force_all_low_n_n_s)) |=> $stable(pins_out))
      else $error("outputs moved without cause");

endmodule : plasma_serial_column_driver

// ===== testbench/display_ctrl_model.sv
// Display controller model driving serial data, shift clock, strobe and force_all_low_n
module display_ctrl_model
   import column_driver_pkg::*;
(
   input  wire logic                     sys_clk,  // Bench clock
   output column_driver_pkg::ctrl_pins_s pins      // Pins towards the driver
);
   timeunit 1ns;
   timeprecision 100ps;

   // Shift clock idles low so that release of reset sees no rising edge
   initial pins = 4'h3;

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   // Phases of four system cycles; the driver samples its pins
   task automatic shift_bit(input logic b);
      pins.serial_data = b;
      tick(4);
      pins.shift_clk = 1'h1;
      tick(4);
      pins.shift_clk = 1'h0;
      tick(2);
      // Hold time is over, so the line stops showing the bit
      pins.serial_data = ~b;
      tick(2);
   endtask : shift_bit

   task automatic set_ctrl(input logic strb_n, input logic sus_n);
      pins.strobe_n        = strb_n;
      pins.force_all_low_n = sus_n;
      tick(5);
   endtask : set_ctrl
endmodule : display_ctrl_model

// ===== testbench/plasma_serial_column_driver_tb.sv
// Self-checking bench for the serial column driver
module plasma_serial_column_driver_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import column_driver_pkg::*;

   // ---------------------------------------------------------------
   // Signals and reference model
   // ---------------------------------------------------------------
   localparam int         TIMEOUT = 5000;
   // Order keeps strobe high whenever force_all_low_n rises
   localparam logic [7:0] MODES   = 8'h4B;
   logic        sys_clk    = 1'h0;
   logic        arst_n     = 1'h0;
   ctrl_pins_s  pins_in;
   drive_pins_s pins_out;
   int          n_mismatch = 0;
   int          checks     = 0;
   int          cycles     = 0;
   stage_vec_t  model      = '0;
   logic [15:0] lfsr       = 16'h0001;
   logic [1:0]  code;

   always #5 sys_clk = ~sys_clk;

   display_ctrl_model display_ctrl_model_i (.sys_clk(sys_clk), .pins(pins_in));

   plasma_serial_column_driver plasma_serial_column_driver_i (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .pins_in  (pins_in),
      .pins_out (pins_out)
   );

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   // Code is {strobe_n, force_all_low_n_n}; force_all_low_n low wins over strobe
   function automatic logic [32:0] exp_out(input logic [1:0] c);
      stage_vec_t e;
      e = !c[0] ? '0 : (c[1] ? '1 : model);
      return {e, model[31]};
   endfunction : exp_out

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic stop_test();
      $display("Mismatches %0d, checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == TIMEOUT) begin
         n_mismatch++;
         stop_test();
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (16) @(posedge sys_clk);
      #1;
      check(pins_out, 33'h0);
      arst_n = 1'h1;
      display_ctrl_model_i.tick(5);
      check(pins_out, exp_out(2'h3));
      // More shifts than stages, so early bits fall off the last stage
      for (int i = 0; i < 48; i++) begin
         lfsr = lfsr_next(lfsr);
         display_ctrl_model_i.shift_bit(lfsr[0]);
         model = {model[30:0], lfsr[0]};
         check(pins_out, exp_out(2'h3));
         for (int m = 0; m < 4; m++) begin
            code = MODES[7-2*m -: 2];
            display_ctrl_model_i.set_ctrl(code[1], code[0]);
            check(pins_out, exp_out(code));
         end
      end
      stop_test();
   end
endmodule : plasma_serial_column_driver_tb
